// >>> verilog/clk_switch_pkg.sv
// Purpose: shared constants and types for the system clock source switch
// Assumes: one 50 MHz core clock; oscillators arrive as sampled levels
// Notes: register offsets and field layouts live here only
package clk_switch_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] OFF_OSC_CONTROL = 4'h0;  // oscillator_control_reg
   localparam logic [3:0] OFF_OSC_STATUS = 4'h1;   // oscillator_status_reg
   localparam logic [3:0] OFF_SWITCH_STATE = 4'h2; // Active source and busy
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // ****************************************
   // Field layout of the control register
   // ****************************************
   localparam int SEL_LSB = 0;   // system_clock_select, two bits
   localparam int FREQ_LSB = 3;  // internal_freq_select, four bits
   localparam logic [1:0] CTRL_SEL_RESET = 2'h0;
   localparam logic [3:0] CTRL_FREQ_RESET = 4'h7;

   // ****************************************
   // System clock select codes
   // ****************************************
   localparam logic [1:0] SEL_CONFIG = 2'h0;   // Source named by the config word
   localparam logic [1:0] SEL_TIMER = 2'h1;    // Secondary timer oscillator

   // ****************************************
   // Default oscillator configuration codes
   // ****************************************
   localparam logic [2:0] CFG_EXT_HIGH = 3'h7;
   localparam logic [2:0] CFG_EXT_MED = 3'h6;
   localparam logic [2:0] CFG_EXT_LOW = 3'h5;
   localparam logic [2:0] CFG_INTERNAL = 3'h4;
   localparam logic [2:0] CFG_XTAL_HIGH = 3'h2;
   localparam logic [2:0] CFG_XTAL_MED = 3'h1;
   localparam logic [2:0] CFG_XTAL_LOW = 3'h0;

   // ****************************************
   // Clock sources, one bit each in the status register
   // ****************************************
   localparam int SRC_W = 6;
   localparam int SRC_FAST = 0;   // fast_internal_osc_16m
   localparam int SRC_MID = 1;    // mid_internal_osc_500k
   localparam int SRC_SLOW = 2;   // slow_internal_osc_31k
   localparam int SRC_EXT = 3;    // Crystal pin or external clock
   localparam int SRC_TIMER = 4;  // Secondary timer oscillator
   localparam int SRC_PLL = 5;    // internal_pll

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int STARTUP_NS = 2000;   // Oscillator start-up wait, plain default
   localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CRYSTAL_STARTUP_NS = 20000;  // oscillator_startup_timer span
   localparam int CRYSTAL_STARTUP_CYCLES =
      (CRYSTAL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Amplifier gain settings
   typedef enum logic [1:0] {
      GAIN_OFF,
      GAIN_LOW,
      GAIN_MED,
      GAIN_HIGH
   } gain_t;

endpackage

// >>> verilog/osc_startup_timer.sv
// Purpose: counts an oscillator start-up wait and reports done
// Assumes: start is a one-cycle pulse on core_clk
// Notes: a fresh start restarts the count
`timescale 1ns/1ps
`default_nettype none
module osc_startup_timer #(
   parameter int CYCLES = 100
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic start,
   output logic done
);
   import clk_switch_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [15:0] count; // Cycles left
      logic busy;         // Wait running
      logic done;         // One-cycle end pulse
   } timer_state_t;

   timer_state_t st;      // Registered state
   timer_state_t next_st; // Next state

   // Count down while busy
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.count = 16'(CYCLES - 1);
         next_st.busy = 1'b1;
      end else if (st.busy) begin
         if (st.count == 16'h0000) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.count = st.count - 16'h0001;
         end
      end
   end

   // Register the state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
endmodule // osc_startup_timer
`default_nettype wire

// >>> verilog/edge_sync.sv
// Purpose: two-flop synchroniser for a sampled oscillator level
// Assumes: input is asynchronous to core_clk
// Notes: edges are found from the second and third stage only
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   import clk_switch_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic meta;  // First stage, read by stage two only
      logic sync;  // Second stage
      logic last;  // Previous synced value
   } sync_state_t;

   sync_state_t st;      // Registered state
   sync_state_t next_st; // Next state

   // Shift chain
   always_comb begin
      next_st.meta = async_in;
      next_st.sync = st.meta;
      next_st.last = st.sync;
   end

   // Register the chain
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.sync;
   assign rise = st.sync & ~st.last;
   assign fall = ~st.sync & st.last;
endmodule // edge_sync
`default_nettype wire

// >>> verilog/system_clock_source_switch.sv
// Purpose: selects and switches the system clock source glitch-free
// Assumes: oscillator outputs arrive as levels sampled by core_clk
// Notes: the gated output clock is a registered level on core_clk
// Notes on behaviour
// - Select field chooses external or internal source
// - Config word picks source after reset
// - Select write switches to timer, internal or config
// - Codes 111/110/101 pick external power range
// - External clock mode skips start-up timer
// - Stopped clock halts logic, keeps state
// - External mode frees crystal out pin
// - Crystal modes set low, medium, high gain
// - Three internal sources: 16M, 500k, 31k; freq code 1110 picks internal_pll instead
// - Powered-down target waits start-up delay first
// - Old falling edge, hold low, new rising
// - Status updated after new clock active
// - Same-source frequency change has no delay
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_switch #(
   parameter int STARTUP_WAIT = clk_switch_pkg::STARTUP_CYCLES,
   parameter int CRYSTAL_WAIT = clk_switch_pkg::CRYSTAL_STARTUP_CYCLES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] defaultOscillatorConfig,
   input wire logic [clk_switch_pkg::ADDR_W-1:0] regAddr,
   input wire logic [clk_switch_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [clk_switch_pkg::DATA_W-1:0] regRdata,
   input wire logic [clk_switch_pkg::SRC_W-1:0] oscIn,
   output logic [clk_switch_pkg::SRC_W-1:0] oscEnable,
   output logic systemClock,
   output logic [1:0] amplifierGain,
   output logic crystalOutIsGpio,
   output logic switchBusy
);
   import clk_switch_pkg::*;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      SW_IDLE,
      SW_STARTUP,
      SW_WAIT_FALL,
      SW_WAIT_RISE,
      SW_STATUS
   } switch_state_t;

   typedef struct packed {
      logic [1:0] clockSelect;     // system_clock_select
      logic [3:0] freqSelect;      // internal_freq_select
      logic [2:0] configLatch;     // Config word caught after reset
      logic booted;                // Config word captured
      logic [2:0] activeSrc;       // Source driving systemClock
      logic [2:0] targetSrc;       // Source being switched to
      logic [3:0] activeFreq;      // Frequency now in effect
      logic [SRC_W-1:0] running;   // Enabled oscillators
      logic [SRC_W-1:0] status;    // oscillator_status_reg
      switch_state_t phase;        // Switch sequence step
      logic busy;                  // Switch in progress
      logic outClock;              // Gated system clock
      logic [1:0] gain;            // Amplifier gain
      logic gpioFree;              // crystal_out_pin freed
      logic [DATA_W-1:0] rdata;    // Read data
   } sw_state_t;

   sw_state_t st;      // Registered state
   sw_state_t next_st; // Next state

   // ****************************************
   // Synchronisers and timer
   // ****************************************
   logic [SRC_W-1:0] oscLevel;  // Synced oscillator levels
   logic [SRC_W-1:0] oscRise;   // Rising edges
   logic [SRC_W-1:0] oscFall;   // Falling edges
   logic timerStart;            // Start-up wait request
   logic timerDone;             // Start-up wait over
   logic timerStartCr;          // Crystal wait request
   logic timerDoneCr;           // Crystal wait over

   // One synchroniser per oscillator line
   genvar g;
   generate
      for (g = 0; g < SRC_W; g++) begin : g_sync
         edge_sync u_sync (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .async_in(oscIn[g]),
            .level(oscLevel[g]),
            .rise(oscRise[g]),
            .fall(oscFall[g])
         );
      end
   endgenerate

   // Internal oscillator wait
   osc_startup_timer #(.CYCLES(STARTUP_WAIT)) u_int_timer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .start(timerStart),
      .done(timerDone)
   );

   // Crystal oscillator wait
   osc_startup_timer #(.CYCLES(CRYSTAL_WAIT)) u_xtal_timer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .start(timerStartCr),
      .done(timerDoneCr)
   );

   // ****************************************
   // Decode functions
   // ****************************************
   // Internal frequency code to source line
   function automatic logic [2:0] freqToSrc(input logic [3:0] f);
      if (f == 4'h0) begin
         freqToSrc = 3'(SRC_SLOW);
      end else if (f < 4'h8) begin
         freqToSrc = 3'(SRC_MID);
      end else if (f == 4'hE) begin
         freqToSrc = 3'(SRC_PLL);
      end else begin
         freqToSrc = 3'(SRC_FAST);
      end
   endfunction

   // Selected source from select field and config word
   function automatic logic [2:0] pickSrc(input logic [1:0] sel, input logic [2:0] cfg,
                                           input logic [3:0] f);
      if (sel == SEL_TIMER) begin
         pickSrc = 3'(SRC_TIMER);
      end else if (sel[1]) begin
         pickSrc = freqToSrc(f);
      end else if (cfg == CFG_INTERNAL) begin
         pickSrc = freqToSrc(f);
      end else begin
         pickSrc = 3'(SRC_EXT);
      end
   endfunction

   // Config code to amplifier gain
   function automatic gain_t gainOf(input logic [2:0] cfg);
      case (cfg)
         CFG_XTAL_LOW: gainOf = GAIN_LOW;
         CFG_XTAL_MED: gainOf = GAIN_MED;
         CFG_XTAL_HIGH: gainOf = GAIN_HIGH;
         default: gainOf = GAIN_OFF;
      endcase
   endfunction

   // External clock mode codes
   function automatic logic isExtClock(input logic [2:0] cfg);
      isExtClock = (cfg == CFG_EXT_HIGH) || (cfg == CFG_EXT_MED) ||
                   (cfg == CFG_EXT_LOW);
   endfunction

   // ****************************************
   // Next-state logic
   // ****************************************
   logic [2:0] wantSrc;      // Source the registers ask for
   logic needSwitch;         // Request differs from what runs
   logic sameSource;         // Only divider changes

   always_comb begin
      next_st = st;
      timerStart = 1'b0;
      timerStartCr = 1'b0;
      wantSrc = pickSrc(st.clockSelect, st.configLatch, st.freqSelect);
      needSwitch = (wantSrc != st.activeSrc) || (st.freqSelect != st.activeFreq);
      sameSource = (wantSrc == st.activeSrc);

      // Capture config word once, after reset release
      if (!st.booted) begin
         next_st.booted = 1'b1;
         next_st.configLatch = defaultOscillatorConfig;
         next_st.activeSrc = pickSrc(SEL_CONFIG, defaultOscillatorConfig,
                                     CTRL_FREQ_RESET);
         next_st.activeFreq = CTRL_FREQ_RESET;
         next_st.gain = gainOf(defaultOscillatorConfig);
         next_st.gpioFree = isExtClock(defaultOscillatorConfig);
         next_st.running[pickSrc(SEL_CONFIG, defaultOscillatorConfig, CTRL_FREQ_RESET)] = 1'b1;
         next_st.running[SRC_SLOW] = 1'b1;
      end

      // Register writes
      if (regWrite && regAddr == OFF_OSC_CONTROL) begin
         next_st.clockSelect = regWdata[SEL_LSB +: 2];
         next_st.freqSelect = regWdata[FREQ_LSB +: 4];
      end

      // Switch sequencer
      case (st.phase)
         SW_IDLE: begin
            if (st.booted && needSwitch) begin
               next_st.targetSrc = wantSrc;
               if (sameSource) begin
                  // Same oscillator, only the tap moves
                  next_st.activeFreq = st.freqSelect;
               end else if (st.running[wantSrc]) begin
                  next_st.phase = SW_WAIT_FALL;
               end else begin
                  next_st.running[wantSrc] = 1'b1;
                  next_st.phase = SW_STARTUP;
                  if (wantSrc == 3'(SRC_EXT) && !isExtClock(st.configLatch)) begin
                     timerStartCr = 1'b1;
                  end else if (wantSrc != 3'(SRC_EXT)) begin
                     timerStart = 1'b1;
                  end else begin
                     // External clock needs no start-up wait
                     next_st.phase = SW_WAIT_FALL;
                  end
               end
            end
         end
         SW_STARTUP: begin
            if (timerDone || timerDoneCr) begin
               next_st.phase = SW_WAIT_FALL;
            end
         end
         SW_WAIT_FALL: begin
            // Hand over only on a low phase of the old clock
            if (oscFall[st.activeSrc]) begin
               next_st.outClock = 1'b0;
               next_st.phase = SW_WAIT_RISE;
            end
         end
         SW_WAIT_RISE: begin
            if (oscRise[st.targetSrc]) begin
               next_st.activeSrc = st.targetSrc;
               next_st.activeFreq = st.freqSelect;
               next_st.phase = SW_STATUS;
            end
         end
         SW_STATUS: begin
            // Retire the old oscillator, keep the slow one for sleep
            for (int i = 0; i < SRC_W; i++) begin
               next_st.running[i] = (3'(i) == st.activeSrc) || (i == SRC_SLOW);
            end
            next_st.phase = SW_IDLE;
         end
         default: begin
            next_st.phase = SW_IDLE;
         end
      endcase

      // Output clock follows the active source unless held low
      // A stopped source freezes the output; all state is kept
      if (st.phase != SW_WAIT_RISE && !(st.phase == SW_WAIT_FALL && oscFall[st.activeSrc])) begin
         next_st.outClock = oscLevel[st.activeSrc];
      end

      // Status shows every enabled oscillator, toggling or not
      // Loaded at boot too, so it never reads empty while sources run
      if (st.phase == SW_STATUS || !st.booted) begin
         next_st.status = next_st.running & oscLevel | next_st.running;
      end
      next_st.busy = (next_st.phase != SW_IDLE); // Busy pin straight from a flop

      // Read data, valid the cycle after the strobe
      next_st.rdata = '0;
      if (regRead) begin
         case (regAddr)
            OFF_OSC_CONTROL: next_st.rdata = DATA_W'({st.freqSelect, 1'b0, st.clockSelect});
            OFF_OSC_STATUS: next_st.rdata = DATA_W'(st.status);
            OFF_SWITCH_STATE: next_st.rdata = DATA_W'({st.phase != SW_IDLE, st.activeSrc});
            default: next_st.rdata = '0;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
         st.clockSelect <= CTRL_SEL_RESET;
         st.freqSelect <= CTRL_FREQ_RESET;
         st.activeFreq <= CTRL_FREQ_RESET;
         st.phase <= SW_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs, all from flip-flops
   // ****************************************
   assign regRdata = st.rdata;
   assign oscEnable = st.running;
   assign systemClock = st.outClock;
   assign amplifierGain = st.gain;
   assign crystalOutIsGpio = st.gpioFree;
   assign switchBusy = st.busy;
endmodule // system_clock_source_switch
`default_nettype wire

// >>> verification/clk_switch_chk.sv
// Purpose: port-level checks for the clock source switch
// Assumes: config word only changes while reset is high
// Notes: bound to every switch instance
`timescale 1ns/1ps
`default_nettype none
module clk_switch_chk #(
   parameter int STARTUP_WAIT = 60,
   parameter int CRYSTAL_WAIT = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] defaultOscillatorConfig,
   input wire logic [clk_switch_pkg::ADDR_W-1:0] regAddr,
   input wire logic [clk_switch_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [clk_switch_pkg::DATA_W-1:0] regRdata,
   input wire logic [clk_switch_pkg::SRC_W-1:0] oscIn,
   input wire logic [clk_switch_pkg::SRC_W-1:0] oscEnable,
   input wire logic systemClock,
   input wire logic [1:0] amplifierGain,
   input wire logic crystalOutIsGpio,
   input wire logic switchBusy
);
   import clk_switch_pkg::*;
   // ****************************************
   // Helper logic
   // ****************************************
   // Waits plus a generous edge hunt on slow sources
   localparam int BUSY_MAX = STARTUP_WAIT + CRYSTAL_WAIT + 200;
   logic [1:0] settleCnt; // Edges since release, saturating
   logic settled; // Config-driven outputs are valid
   // Outputs follow the config from the first edge after release; checks wait for the third
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         settleCnt <= 2'h0;
      end else if (settleCnt != 2'h3) begin
         settleCnt <= settleCnt + 2'h1;
      end
   end
   assign settled = (settleCnt == 2'h3);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ****************************************
   // Switch sequence steps
   // ****************************************
   sequence s_switch_start;
      $rose(switchBusy);
   endsequence
   sequence s_switch_done;
      !switchBusy;
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   a_reset_quiet: assert property (
      $fell(sys_rst) |-> (regRdata == 8'h00) && !systemClock && !switchBusy)
      else $error("outputs not quiet at reset release");
   a_rdata_idle: assert property (
      !$past(regRead) |-> regRdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (
      regRead && (regAddr > OFF_SWITCH_STATE) |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_busy_readback: assert property (
      regRead && (regAddr == OFF_SWITCH_STATE) |=> regRdata[3] == $past(switchBusy))
      else $error("busy bit does not match switch state");
   a_gpio_ext_mode: assert property (
      settled |-> crystalOutIsGpio == (defaultOscillatorConfig >= CFG_EXT_LOW))
      else $error("crystal out pin use wrong for config");
   a_gain_off_ext: assert property (
      settled && defaultOscillatorConfig[2] |-> amplifierGain == GAIN_OFF)
      else $error("amplifier on outside crystal modes");
   a_slow_always_on: assert property (
      settled |-> oscEnable[SRC_SLOW])
      else $error("slow oscillator powered down");
   a_busy_bounded: assert property (
      s_switch_start |-> ##[1:BUSY_MAX] s_switch_done)
      else $error("clock switch never completes");
endmodule // clk_switch_chk

bind system_clock_source_switch clk_switch_chk #(
   .STARTUP_WAIT(STARTUP_WAIT),
   .CRYSTAL_WAIT(CRYSTAL_WAIT)
) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .defaultOscillatorConfig(defaultOscillatorConfig), .regAddr(regAddr),
   .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .oscIn(oscIn), .oscEnable(oscEnable), .systemClock(systemClock),
   .amplifierGain(amplifierGain), .crystalOutIsGpio(crystalOutIsGpio),
   .switchBusy(switchBusy));
`default_nettype wire

// >>> verification/test_system_clock_source_switch.sv
// Purpose: self-checking bench for the clock source switch
// Assumes: oscillators modelled as divided core_clk levels
// Notes: start-up wait shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_source_switch;
   import clk_switch_pkg::*;
   localparam int SW = 60; // Start-up wait, long enough to tell from edge hunts
   logic core_clk, sys_rst, regWrite, regRead, oscRun;
   logic [2:0] defaultOscillatorConfig;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWdata;
   logic [DATA_W-1:0] regRdata;
   logic [SRC_W-1:0] oscIn;
   logic [SRC_W-1:0] oscEnable;
   logic systemClock, crystalOutIsGpio, switchBusy;
   logic [1:0] amplifierGain;
   logic [7:0] oscCnt; // Divider behind the oscillator levels
   int err_total, total_checks;
   int cycles = 0; // Watchdog count

   system_clock_source_switch #(.STARTUP_WAIT(SW), .CRYSTAL_WAIT(4)) u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst),
      .defaultOscillatorConfig(defaultOscillatorConfig), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .oscIn(oscIn), .oscEnable(oscEnable),
      .systemClock(systemClock), .amplifierGain(amplifierGain),
      .crystalOutIsGpio(crystalOutIsGpio), .switchBusy(switchBusy));

   // ****************************************
   // Clock, oscillators, watchdog
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Sources toggle at three rates, shared in pairs; oscRun low freezes them all
   always @(posedge core_clk) begin
      if (oscRun) begin
         oscCnt <= oscCnt + 8'h01;
      end
      oscIn <= {oscCnt[2], oscCnt[3], oscCnt[1], oscCnt[3], oscCnt[2], oscCnt[1]};
   end
   // A hang is cut short well past the expected run length
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         $display("BAD watchdog expected 0 seen %0d", cycles);
         conclude();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 v = regRdata;
   endtask
   task automatic do_reset(input logic [2:0] cfg);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      defaultOscillatorConfig <= cfg;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (12) @(posedge core_clk);
   endtask
   // Busy cycles counted; low tells whether the clock was parked low
   task automatic wait_switch(output int n, output logic low);
      int i;
      n = 0;
      low = 1'b0;
      for (i = 0; i < 10 && switchBusy !== 1'b1; i++) @(posedge core_clk) #1;
      while (switchBusy === 1'b1 && n < 500) begin
         low = (systemClock === 1'b0);
         n++;
         @(posedge core_clk) #1;
      end
      chk("switch end", 8'h00, {7'h0, switchBusy});
   endtask
   task automatic toggles(output logic t);
      logic s0, s1;
      s0 = 1'b0;
      s1 = 1'b0;
      repeat (40) begin
         @(posedge core_clk) #1;
         if (systemClock === 1'b0) s0 = 1'b1;
         if (systemClock === 1'b1) s1 = 1'b1;
      end
      t = s0 & s1;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_reset_values();
      logic [7:0] v;
      do_reset(CFG_INTERNAL);
      rd(OFF_OSC_CONTROL, v);
      chk("control", {1'b0, CTRL_FREQ_RESET, 1'b0, CTRL_SEL_RESET}, v);
      rd(OFF_SWITCH_STATE, v);
      chk("state", 8'(SRC_MID), v);
      rd(OFF_OSC_STATUS, v);
      chk("status boot", 8'h06, v);
      wr(4'hF, 8'hFF);
      rd(4'hF, v);
      chk("unmapped", 8'h00, v);
      rd(OFF_OSC_CONTROL, v);
      chk("control kept", 8'h38, v);
      $display("test reset_values done, mismatches %0d", err_total);
   endtask
   task automatic test_config_modes();
      logic [7:0] v;
      for (int c = 0; c < 8; c++) begin
         if (c != 3) begin
            do_reset(3'(c));
            chk("gain", (c < 3) ? 8'(c + 1) : 8'h00, {6'h0, amplifierGain});
            chk("gpio", 8'(c >= 5), {7'h0, crystalOutIsGpio});
            rd(OFF_SWITCH_STATE, v);
            chk("source", (c == 4) ? 8'(SRC_MID) : 8'(SRC_EXT), v);
         end
      end
      $display("test config_modes done, mismatches %0d", err_total);
   endtask
   task automatic test_internal_switch();
      logic [7:0] v;
      int n;
      logic low;
      do_reset(CFG_INTERNAL);
      wr(OFF_OSC_CONTROL, 8'h0A);
      wait_switch(n, low);
      chk("mid to mid", 8'h00, 8'(n));
      wr(OFF_OSC_CONTROL, 8'h7A);
      wait_switch(n, low);
      chk("startup wait", 8'h01, 8'(n >= SW));
      chk("held low", 8'h01, {7'h0, low});
      chk("fast powered", 8'h01, {7'h0, oscEnable[SRC_FAST]});
      rd(OFF_OSC_STATUS, v);
      chk("status fast", 8'h01, {7'h0, v[SRC_FAST]});
      rd(OFF_SWITCH_STATE, v);
      chk("active fast", 8'(SRC_FAST), v);
      wr(OFF_OSC_CONTROL, 8'h42);
      wait_switch(n, low);
      chk("fast to fast", 8'h00, 8'(n));
      $display("test internal_switch done, mismatches %0d", err_total);
   endtask
   task automatic test_external();
      logic [7:0] v;
      int n;
      logic low, t, held;
      do_reset(CFG_EXT_HIGH);
      toggles(t);
      chk("ext runs", 8'h01, {7'h0, t});
      wr(OFF_OSC_CONTROL, 8'h39);
      wait_switch(n, low);
      rd(OFF_SWITCH_STATE, v);
      chk("timer", 8'(SRC_TIMER), v);
      wr(OFF_OSC_CONTROL, 8'h38);
      wait_switch(n, low);
      chk("no ext wait", 8'h01, 8'(n > 0 && n < SW));
      rd(OFF_SWITCH_STATE, v);
      chk("back to ext", 8'(SRC_EXT), v);
      oscRun <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1 t = systemClock;
      held = 1'b1;
      repeat (10) begin
         @(posedge core_clk) #1;
         if (systemClock !== t) held = 1'b0;
      end
      chk("halted", 8'h01, {7'h0, held});
      oscRun <= 1'b1;
      toggles(t);
      chk("resumed", 8'h01, {7'h0, t});
      rd(OFF_SWITCH_STATE, v);
      chk("state kept", 8'(SRC_EXT), v);
      $display("test external done, mismatches %0d", err_total);
   endtask

   // ****************************************
   // Verdict and main sequence
   // ****************************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      defaultOscillatorConfig = CFG_INTERNAL;
      oscRun = 1'b1;
      oscCnt = 8'h00;
      oscIn = 6'h00;
      err_total = 0;
      total_checks = 0;
      test_reset_values();
      test_config_modes();
      test_internal_switch();
      test_external();
      conclude();
   end
endmodule // test_system_clock_source_switch
`default_nettype wire
